/* core/sdlctx_top.sv */
// Transmit side of one bit-oriented framed serial channel.
`timescale 1ns/1ps
`default_nettype none

module sdlctx_top import sdlctx_pkg::*; #(
   parameter bit IS_CHANNEL_B = 1'b1
) (
   // System clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Transmit clock of the link.
   input wire logic tx_clk,
   // Character write port.
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   output logic wr_ready,
   // Configuration levels.
   input wire logic tx_enable,
   input wire logic transmit_check_enable_bit,
   input wire logic auto_enables,
   input wire logic [1:0] width_code,
   input wire logic ext_int_enable,
   input wire logic tx_int_enable,
   input wire logic wait_ready_enable,
   input wire logic status_affects_vector,
   input wire logic [7:0] vector_reg,
   // Command pulses.
   input wire logic cmd_preset_check,
   input wire logic cmd_reset_eom,
   input wire logic cmd_send_abort,
   input wire logic cmd_reset_tx_pending,
   input wire logic cmd_reset_ext_status,
   // Modem pins.
   input wire logic cts_n,
   input wire logic carrier_detect_input_n,
   // Status and interrupt requests.
   output logic tx_buffer_empty,
   output logic underrun_end_of_message_latch,
   output logic ext_int_req,
   output logic tx_int_req,
   output logic ready_n,
   output logic [7:0] vector_out,
   // Serial line.
   output logic txd
);

   ////////////////////////////////////////////////////////////////////////////
   // Crossings between the two domains.

   sdlctx_ctl_type ctl_sys;
   sdlctx_ctl_type ctl_link;
   sdlctx_stat_type stat_link;
   sdlctx_stat_type stat_sys;
   logic link_rst_n;
   sdlctx_link_type l;
   sdlctx_link_type next_l;
   sdlctx_sys_type s;
   sdlctx_sys_type next_s;

   // The link reset comes from the system reset, so its own stages need none.
   sdlctx_sync #(.W(1)) u_link_rst (
      .clk(tx_clk),
      .rst_n(1'b1),
      .d(rst_n),
      .q(link_rst_n)
   );

   sdlctx_sync #(.W($bits(sdlctx_ctl_type))) u_to_link (
      .clk(tx_clk),
      .rst_n(link_rst_n),
      .d(ctl_sys),
      .q(ctl_link)
   );

   sdlctx_sync #(.W($bits(sdlctx_stat_type))) u_to_sys (
      .clk(clk_sys),
      .rst_n(rst_n),
      .d(stat_link),
      .q(stat_sys)
   );

   always_comb begin
      ctl_sys.tx_enable = tx_enable;
      ctl_sys.check_enable = transmit_check_enable_bit;
      ctl_sys.auto_enables = auto_enables;
      ctl_sys.width_code = width_code;
      ctl_sys.buf_req = s.buf_req;
      ctl_sys.preset_req = s.preset_req;
      ctl_sys.eom_reset_req = s.eom_reset_req;
      ctl_sys.abort_req = s.abort_req;
      ctl_sys.cts_n = cts_n;
      stat_link.buf_ack = l.buf_ack;
      stat_link.eom = l.eom;
      stat_link.in_check = (l.state == ST_CHECK);
      stat_link.in_flag = (l.state == ST_FLAG);
      stat_link.cts_n = cts_n;
      stat_link.carrier_detect_n = carrier_detect_input_n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link side: bit sequencer on the transmit clock.

   logic [15:0] stepped;
   logic line_bit;
   logic stuffable;
   logic [2:0] flag_idx;
   logic abort_new;
   logic load_data;

   sdlctx_check_step u_step (
      .check(l.check),
      .bit_in(line_bit),
      .next_check(stepped)
   );

   // Only the buffered byte crosses without a synchroniser; it is held stable from request to acknowledge.
   always_comb begin
      next_l = l;
      next_l.start_check = 1'b0;
      next_l.start_flag = 1'b0;
      next_l.preset_take = 1'b0;
      load_data = 1'b0;
      line_bit = 1'b1;
      stuffable = 1'b0;
      flag_idx = 3'h0;
      abort_new = (ctl_link.abort_req != l.abort_seen);
      if (ctl_link.preset_req != l.preset_seen) begin
         next_l.preset_seen = ctl_link.preset_req;
         next_l.check = `SDLCTX_CHECK_PRESET;
         next_l.preset_take = 1'b1;
      end
      if (ctl_link.eom_reset_req != l.eom_seen) begin
         next_l.eom_seen = ctl_link.eom_reset_req;
         next_l.eom = 1'b0;
      end
      if (abort_new) begin
         next_l.abort_seen = ctl_link.abort_req;
         next_l.state = ST_ABORT;
         next_l.shift = `SDLCTX_ABORT_FILL;
         next_l.left = `SDLCTX_ABORT_BITS;
         next_l.check_flags = 1'b0;
         next_l.was_data = 1'b0;
      end else if (l.left == 5'h00) begin
         if (!ctl_link.tx_enable || (ctl_link.auto_enables && ctl_link.cts_n)) begin
            next_l.state = ST_MARK;
            next_l.was_data = 1'b0;
         end else if (l.state == ST_MARK || l.state == ST_ABORT) begin
            next_l.state = ST_FLAG;
            next_l.shift = {8'h00, `SDLCTX_FLAG_PATTERN};
            next_l.left = `SDLCTX_FLAG_BITS;
            next_l.start_flag = 1'b1;
         end else if (ctl_link.buf_req != l.buf_ack) begin
            load_data = 1'b1;
            next_l.buf_ack = ctl_link.buf_req;
            next_l.state = ST_DATA;
            next_l.shift = {8'h00, s.buf_data};
            next_l.left = sdlctx_width(ctl_link.width_code);
            next_l.was_data = 1'b1;
         end else if (l.was_data && !l.eom) begin
            next_l.state = ST_CHECK;
            next_l.shift = ~l.check;
            next_l.left = `SDLCTX_CHECK_BITS;
            next_l.check_flags = 1'b0;
            next_l.was_data = 1'b0;
            next_l.start_check = 1'b1;
         end else begin
            next_l.start_flag = (l.state != ST_FLAG);
            next_l.state = ST_FLAG;
            next_l.shift = {8'h00, `SDLCTX_FLAG_PATTERN};
            next_l.left = `SDLCTX_FLAG_BITS;
            next_l.was_data = 1'b0;
         end
      end else if (l.state == ST_CHECK && !ctl_link.tx_enable) begin
         next_l.check_flags = 1'b1;
      end
      if (next_l.start_check) begin
         next_l.eom = 1'b1;
      end
      stuffable = (next_l.state == ST_DATA) || (next_l.state == ST_CHECK && !next_l.check_flags);
      flag_idx = 3'(`SDLCTX_CHECK_BITS - next_l.left);
      if (next_l.state == ST_MARK) begin
         next_l.txd = 1'b1;
         next_l.ones = 3'h0;
      end else if (stuffable && l.ones == `SDLCTX_ONES_LIMIT) begin
         next_l.txd = 1'b0;
         next_l.ones = 3'h0;
      end else begin
         if (next_l.state == ST_CHECK && next_l.check_flags) begin
            line_bit = 1'(`SDLCTX_FLAG_PATTERN >> flag_idx);
         end else begin
            line_bit = next_l.shift[0];
         end
         next_l.txd = line_bit;
         next_l.shift = {1'b0, next_l.shift[15:1]};
         next_l.left = next_l.left - 5'h01;
         if (next_l.state == ST_DATA && ctl_link.check_enable) begin
            next_l.check = stepped;
         end
         if (stuffable && line_bit) begin
            next_l.ones = l.ones + 3'h1;
         end else begin
            next_l.ones = 3'h0;
         end
      end
   end

   always_ff @(posedge tx_clk) begin
      if (!link_rst_n) begin
         l <= '0;
         l.state <= ST_MARK;
         l.txd <= 1'b1;
         l.eom <= 1'b1;
         l.check <= `SDLCTX_CHECK_PRESET;
      end else begin
         l <= next_l;
      end
   end

   assign txd = l.txd;

   ////////////////////////////////////////////////////////////////////////////
   // System side: buffer, commands, events and vector.

   logic ext_event;

   always_comb begin
      next_s = s;
      ext_event = (stat_sys.cts_n != s.prev[3]) || (stat_sys.carrier_detect_n != s.prev[2]) ||
                  (stat_sys.in_check && !s.prev[1]) || (stat_sys.in_flag && !s.prev[0]) ||
                  (stat_sys.eom && !s.prev[4]);
      next_s.prev = {stat_sys.eom, stat_sys.cts_n, stat_sys.carrier_detect_n, stat_sys.in_check, stat_sys.in_flag};
      if (cmd_preset_check) begin
         next_s.preset_req = !s.preset_req;
      end
      if (cmd_reset_eom) begin
         next_s.eom_reset_req = !s.eom_reset_req;
      end
      if (cmd_send_abort) begin
         next_s.abort_req = !s.abort_req;
      end
      if (cmd_reset_tx_pending) begin
         next_s.tx_pend = 1'b0;
      end
      if (wr_valid && !s.buf_full) begin
         next_s.buf_data = wr_data;
         next_s.buf_full = 1'b1;
         next_s.buf_req = !s.buf_req;
         next_s.armed = 1'b1;
         next_s.tx_pend = 1'b0;
      end
      if (stat_sys.buf_ack != s.ack_seen) begin
         next_s.ack_seen = stat_sys.buf_ack;
         next_s.buf_full = 1'b0;
         if (s.armed) begin
            next_s.tx_pend = 1'b1;
         end
      end
      if (cmd_reset_ext_status) begin
         next_s.ext_pend = 1'b0;
      end
      if (ext_event) begin
         next_s.ext_pend = 1'b1;
      end
      if (!IS_CHANNEL_B) begin
         next_s.vector = `SDLCTX_VECTOR_ABSENT;
      end else if (!status_affects_vector) begin
         next_s.vector = vector_reg;
      end else if (next_s.ext_pend && ext_int_enable) begin
         next_s.vector = {vector_reg[7:4], `SDLCTX_CAUSE_EXT, vector_reg[0]};
      end else if (next_s.tx_pend && tx_int_enable) begin
         next_s.vector = {vector_reg[7:4], `SDLCTX_CAUSE_TX, vector_reg[0]};
      end else begin
         next_s.vector = {vector_reg[7:4], `SDLCTX_CAUSE_NONE, vector_reg[0]};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
         s.prev <= 5'h1F;
      end else begin
         s <= next_s;
      end
   end

   assign wr_ready = !s.buf_full;
   assign tx_buffer_empty = !s.buf_full;
   assign underrun_end_of_message_latch = stat_sys.eom;
   assign ext_int_req = s.ext_pend && ext_int_enable;
   assign tx_int_req = s.tx_pend && tx_int_enable;
   assign ready_n = !(wait_ready_enable && !s.buf_full);
   assign vector_out = s.vector;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the link side.

   logic abort_pend;
   assign abort_pend = (ctl_link.abort_req != l.abort_seen);

   sequence flag_bits_s;
      !l.txd ##1 l.txd [*6] ##1 !l.txd;
   endsequence

   sequence check_slot_s;
      (l.state == ST_CHECK) [*8];
   endsequence

   flag_pattern_a: assert property (@(posedge tx_clk) disable iff (!link_rst_n || abort_pend)
      l.start_flag |-> flag_bits_s) else $error("flag pattern wrong");

   check_slot_a: assert property (@(posedge tx_clk) disable iff (!link_rst_n || abort_pend)
      l.start_check |-> check_slot_s) else $error("check slot cut short");

   check_preset_a: assert property (@(posedge tx_clk) disable iff (!link_rst_n)
      l.preset_take && l.state != ST_DATA |-> l.check == `SDLCTX_CHECK_PRESET) else $error("check not preset");

   stuff_zero_a: assert property (@(posedge tx_clk) disable iff (!link_rst_n)
      $past(l.ones) == `SDLCTX_ONES_LIMIT && (l.state == ST_DATA) |-> !l.txd) else $error("no zero after five ones");

   lsb_first_a: assert property (@(posedge tx_clk) disable iff (!link_rst_n)
      load_data && l.ones != `SDLCTX_ONES_LIMIT |=> l.txd == $past(s.buf_data[0])) else $error("first bit not lsb");

   mark_line_a: assert property (@(posedge tx_clk) disable iff (!link_rst_n)
      l.state == ST_MARK |-> l.txd) else $error("line not marking");

   eom_on_check_a: assert property (@(posedge tx_clk) disable iff (!link_rst_n)
      l.start_check |-> l.eom && !$past(l.eom)) else $error("latch not set by check");

   no_load_off_a: assert property (@(posedge tx_clk) disable iff (!link_rst_n)
      load_data |-> ctl_link.tx_enable && l.state != ST_MARK) else $error("load while disabled");

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the system side.

   ext_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ext_event |=> s.ext_pend) else $error("event lost");

   tx_empty_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s.buf_full && stat_sys.buf_ack != s.ack_seen && s.armed && tx_int_enable |=> tx_int_req) else $error("no empty request");

   vector_chan_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !IS_CHANNEL_B |=> vector_out == `SDLCTX_VECTOR_ABSENT) else $error("vector in first channel");

endmodule // sdlctx_top

`default_nettype wire

/* inc/sdlctx_consts.svh */
// Constants of the framed serial transmitter: patterns, counts and vector codes.
`ifndef SDLCTX_CONSTS_SVH
`define SDLCTX_CONSTS_SVH

`define SDLCTX_FLAG_PATTERN 8'h7E
`define SDLCTX_FLAG_BITS 5'h08
`define SDLCTX_ABORT_BITS 5'h08
`define SDLCTX_ABORT_FILL 16'hFFFF
`define SDLCTX_CHECK_BITS 5'h10
`define SDLCTX_CHECK_PRESET 16'hFFFF
`define SDLCTX_CHECK_POLY_REFL 16'h8408
`define SDLCTX_ONES_LIMIT 3'h5
`define SDLCTX_WIDTH_CODE_5 2'h0
`define SDLCTX_WIDTH_CODE_6 2'h2
`define SDLCTX_WIDTH_CODE_7 2'h1
`define SDLCTX_WIDTH_CODE_8 2'h3
`define SDLCTX_CAUSE_EXT 3'h5
`define SDLCTX_CAUSE_TX 3'h4
`define SDLCTX_CAUSE_NONE 3'h3
`define SDLCTX_VECTOR_ABSENT 8'h00

`endif

/* inc/sdlctx_pkg.sv */
// Types shared by the framed serial transmitter modules.
`include "sdlctx_consts.svh"

package sdlctx_pkg;

   typedef enum logic [2:0] {
      ST_MARK,
      ST_FLAG,
      ST_DATA,
      ST_CHECK,
      ST_ABORT
   } sdlctx_line_type;

   // Levels handed from the system side to the link side.
   typedef struct packed {
      logic tx_enable;
      logic check_enable;
      logic auto_enables;
      logic [1:0] width_code;
      logic buf_req;
      logic preset_req;
      logic eom_reset_req;
      logic abort_req;
      logic cts_n;
   } sdlctx_ctl_type;

   // Levels handed from the link side back to the system side.
   typedef struct packed {
      logic buf_ack;
      logic eom;
      logic in_check;
      logic in_flag;
      logic cts_n;
      logic carrier_detect_n;
   } sdlctx_stat_type;

   typedef struct packed {
      sdlctx_line_type state;
      logic [15:0] shift;
      logic [4:0] left;
      logic [2:0] ones;
      logic [15:0] check;
      logic check_flags;
      logic was_data;
      logic eom;
      logic txd;
      logic buf_ack;
      logic preset_seen;
      logic eom_seen;
      logic abort_seen;
      logic start_check;
      logic start_flag;
      logic preset_take;
   } sdlctx_link_type;

   typedef struct packed {
      logic [7:0] buf_data;
      logic buf_full;
      logic buf_req;
      logic ack_seen;
      logic preset_req;
      logic eom_reset_req;
      logic abort_req;
      logic armed;
      logic tx_pend;
      logic ext_pend;
      logic [4:0] prev;
      logic [7:0] vector;
   } sdlctx_sys_type;

   function automatic logic [4:0] sdlctx_width(input logic [1:0] code);
      case (code)
         `SDLCTX_WIDTH_CODE_5: sdlctx_width = 5'h05;
         `SDLCTX_WIDTH_CODE_6: sdlctx_width = 5'h06;
         `SDLCTX_WIDTH_CODE_7: sdlctx_width = 5'h07;
         default: sdlctx_width = 5'h08;
      endcase
   endfunction

endpackage

/* core/sdlctx_sync.sv */
// Three-stage input synchroniser whose output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module sdlctx_sync import sdlctx_pkg::*; #(
   parameter int W = 1
) (
   // Clock and reset of the receiving domain.
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous input and its settled copy.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sdlctx_sync_type;

   sdlctx_sync_type s;
   sdlctx_sync_type next_s;

   initial begin
      if (W < 1) begin
         $error("sdlctx_sync width must be at least one");
      end
   end

   always_comb begin
      next_s = s;
      next_s.s1 = d;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      if (s.s2 == s.s3) begin
         next_s.q = s.s3;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.q;

endmodule // sdlctx_sync

`default_nettype wire

/* core/sdlctx_check_step.sv */
// One bit step of the reflected sixteen-bit frame check generator.
`timescale 1ns/1ps
`default_nettype none

module sdlctx_check_step import sdlctx_pkg::*; (
   // Present value and the bit that enters it.
   input wire logic [15:0] check,
   input wire logic bit_in,
   // Value after the bit.
   output logic [15:0] next_check
);

   logic feedback;

   always_comb begin
      feedback = check[0] ^ bit_in;
      next_check = {1'b0, check[15:1]} ^ (feedback ? `SDLCTX_CHECK_POLY_REFL : 16'h0000);
   end

endmodule // sdlctx_check_step

`default_nettype wire

/* verif/sdlctx_remote_rx.sv */
// Remote receiving station model that recovers frames from the serial line.
`timescale 1ns/1ps
`default_nettype none

module sdlctx_remote_rx (
   // Link clock and serial line.
   input wire logic tx_clk,
   input wire logic txd
);
   int ones = 0;
   int flags = 0;
   int aborts = 0;
   int frames = 0;
   logic cur[$];
   logic last[$];

   ////////////////////////////////////////////////////////////////////////////
   // Bits are launched on the rising edge, so they are taken on the falling one.
   always @(negedge tx_clk) begin
      if (txd === 1'b1) begin
         ones = ones + 1;
         if (ones < 7) begin
            cur.push_back(1'b1);
         end else if (ones == 7) begin
            aborts = aborts + 1;
            cur.delete();
         end
      end else begin
         if (ones == 6) begin
            flags = flags + 1;
            if (cur.size() > 7) begin
               last = cur[0:cur.size() - 8];
               frames = frames + 1;
            end
            cur.delete();
         end else if (ones != 5) begin
            cur.push_back(1'b0);
         end
         ones = 0;
      end
   end

endmodule // sdlctx_remote_rx

`default_nettype wire

/* verif/sdlctx_top_tb_top.sv */
// Self-checking testbench of the framed serial transmitter.
`timescale 1ns/1ps
`default_nettype none
`include "sdlctx_consts.svh"

module sdlctx_top_tb_top import sdlctx_pkg::*; ;
   localparam int C_PRESET = 0;
   localparam int C_EOM = 1;
   localparam int C_ABORT = 2;
   localparam int C_TXP = 3;
   localparam int C_EXT = 4;
   logic clk_sys = 1'b0;
   logic tx_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr_valid = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic tx_enable = 1'b0;
   logic auto_en = 1'b1;
   logic [1:0] width_code = `SDLCTX_WIDTH_CODE_8;
   logic [3:0] ie = 4'h0;
   logic [4:0] cmd = 5'h00;
   logic cts_n = 1'b1;
   logic cd_n = 1'b1;
   logic wr_ready;
   logic tx_empty;
   logic eom;
   logic ext_req;
   logic tx_req;
   logic ready_n;
   logic txd;
   logic [7:0] vector_out;
   logic [15:0] crc;
   logic exp_bits[$];
   int num_errors = 0;
   int cmp_count = 0;
   int base;
   wire [1:0] obs = {ext_req, wr_ready};

   sdlctx_top dut_u (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tx_clk(tx_clk),
      .wr_valid(wr_valid),
      .wr_data(wr_data),
      .wr_ready(wr_ready),
      .tx_enable(tx_enable),
      .transmit_check_enable_bit(1'b1),
      .auto_enables(auto_en),
      .width_code(width_code),
      .ext_int_enable(ie[3]),
      .tx_int_enable(ie[2]),
      .wait_ready_enable(ie[1]),
      .status_affects_vector(ie[0]),
      .vector_reg(8'hA0),
      .cmd_preset_check(cmd[C_PRESET]),
      .cmd_reset_eom(cmd[C_EOM]),
      .cmd_send_abort(cmd[C_ABORT]),
      .cmd_reset_tx_pending(cmd[C_TXP]),
      .cmd_reset_ext_status(cmd[C_EXT]),
      .cts_n(cts_n),
      .carrier_detect_input_n(cd_n),
      .tx_buffer_empty(tx_empty),
      .underrun_end_of_message_latch(eom),
      .ext_int_req(ext_req),
      .tx_int_req(tx_req),
      .ready_n(ready_n),
      .vector_out(vector_out),
      .txd(txd)
   );

   sdlctx_remote_rx partner_u (
      .tx_clk(tx_clk),
      .txd(txd)
   );

   ////////////////////////////////////////////////////////////////////////////
   always #25 clk_sys = ~clk_sys;

   initial begin
      #7;
      forever #32 tx_clk = ~tx_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic check_bit(input string name, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic check_vec(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_frame();
      int bad;
      cmp_count++;
      bad = (partner_u.last.size() != exp_bits.size());
      foreach (exp_bits[i]) begin
         if (bad == 0 && partner_u.last[i] !== exp_bits[i]) begin
            bad = 1;
         end
      end
      if (bad != 0) begin
         num_errors++;
         $display("wrong value frame expected %p seen %p", exp_bits, partner_u.last);
      end
   endtask

   // Values are read at the edge, before that edge's updates land.
   task automatic wait_lvl(input int idx, input logic lvl);
      for (int i = 0; i < 4000; i++) begin
         @(posedge clk_sys);
         if (obs[idx] === lvl) begin
            return;
         end
      end
      num_errors++;
      $display("wrong value wait %0d expected %b seen %b", idx, lvl, obs[idx]);
      final_report();
   endtask

   task automatic wait_cnt(input int which, input int n);
      for (int i = 0; i < 6000; i++) begin
         @(posedge clk_sys);
         if ((which == 0 ? partner_u.flags : partner_u.frames) >= n) begin
            return;
         end
      end
      num_errors++;
      $display("wrong value partner count expected %0d seen %0d", n, partner_u.frames);
      final_report();
   endtask

   task automatic pulse(input int k);
      cmd[k] <= 1'b1;
      @(posedge clk_sys);
      cmd[k] <= 1'b0;
      tick(12);
   endtask

   task automatic write_char(input logic [7:0] d);
      wait_lvl(0, 1'b1);
      wr_data <= d;
      wr_valid <= 1'b1;
      @(posedge clk_sys);
      wr_valid <= 1'b0;
      @(posedge clk_sys);
      check_bit("ready_n", 1'b1, ready_n);
   endtask

   task automatic add_char(input logic [7:0] d, input int w);
      for (int i = 0; i < w; i++) begin
         exp_bits.push_back(d[i]);
         crc = (crc >> 1) ^ ((crc[0] ^ d[i]) ? `SDLCTX_CHECK_POLY_REFL : 16'h0000);
      end
   endtask

   // One character per frame: the buffer round trip across the domains is longer than a character time.
   task automatic send_frame(input logic [7:0] d, input int w, input int n);
      pulse(C_PRESET);
      crc = `SDLCTX_CHECK_PRESET;
      exp_bits.delete();
      write_char(d);
      add_char(d, w);
      pulse(C_EOM);
      crc = ~crc;
      for (int i = 0; i < 16; i++) begin
         exp_bits.push_back(crc[i]);
      end
      wait_cnt(1, n);
      check_frame();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      // Six system clock edges of reset also cover the link reset stages.
      tick(6);
      check_bit("wr_ready", 1'b1, wr_ready);
      check_bit("tx_buffer_empty", 1'b1, tx_empty);
      check_bit("ext_int_req", 1'b0, ext_req);
      check_bit("tx_int_req", 1'b0, tx_req);
      check_vec("vector_out", 8'h00, vector_out);
      rst_n <= 1'b1;
      tick(20);
      check_bit("txd", 1'b1, txd);
      cd_n <= 1'b0;
      tick(10);
      check_bit("ext_int_req", 1'b0, ext_req);
      ie <= 4'hF;
      tick(3);
      check_bit("ext_int_req", 1'b1, ext_req);
      check_vec("vector_out", 8'hAA, vector_out);
      check_bit("ready_n", 1'b0, ready_n);
      pulse(C_EXT);
      check_bit("ext_int_req", 1'b0, ext_req);
      tx_enable <= 1'b1;
      tick(100);
      check_bit("flags", 1'b0, partner_u.flags != 0);
      cts_n <= 1'b0;
      wait_lvl(1, 1'b1);
      wait_cnt(0, 1);
      check_bit("frames", 1'b0, partner_u.frames != 0);
      tick(200);
      pulse(C_EXT);
      send_frame(8'h5A, 8, 1);
      send_frame(8'hFF, 8, 2);
      width_code <= `SDLCTX_WIDTH_CODE_5;
      send_frame(8'h13, 5, 3);
      tick(20);
      check_bit("eom latch", 1'b1, eom);
      check_bit("ext_int_req", 1'b1, ext_req);
      check_bit("tx_int_req", 1'b1, tx_req);
      pulse(C_TXP);
      check_bit("tx_int_req", 1'b0, tx_req);
      width_code <= `SDLCTX_WIDTH_CODE_8;
      tx_enable <= 1'b0;
      tick(30);
      base = 0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         base += (txd !== 1'b1);
      end
      check_bit("marking", 1'b1, base == 0);
      exp_bits.delete();
      write_char(8'h3C);
      add_char(8'h3C, 8);
      pulse(C_ABORT);
      tick(150);
      check_bit("wr_ready", 1'b0, wr_ready);
      check_bit("txd", 1'b1, txd);
      tx_enable <= 1'b1;
      wait_cnt(1, 4);
      check_frame();
      final_report();
   end

endmodule // sdlctx_top_tb_top

`default_nettype wire
